// file: rtl/wakeup_cfg_pkg.sv
// package: strap layout, widths, timing counts and carrier structs for wake-up config
package wakeup_cfg_pkg;
   // =====================================================
   // widths and field positions
   localparam int WAKE_W        = 16;
   localparam int GROUP_W       = 8;
   localparam int ADDR20_W      = 20;
   localparam int ADDR24_W      = 24;
   localparam int SEG_SHIFT     = 4;
   localparam int PAGE_LSB      = 20;
   localparam int PAGE_W        = 4;
   localparam int PORT8_W       = 8;
   localparam int IRQ_LINES     = 8;
   localparam int IRQ_SEL_W     = 3;
   localparam logic [PAGE_W-1:0] PAGE_LOW  = 4'h0;
   localparam logic [PAGE_W-1:0] PAGE_HIGH = 4'hf;
   // =====================================================
   // synchroniser and settle timing
   localparam int SYNC_STAGES   = 3;
   localparam int CLK_HZ        = 20000000;
   localparam int SETTLE_NS     = 200;   // strap settle time after reset release
   localparam int SETTLE_CYC    = (SETTLE_NS * (CLK_HZ / 1000000) + 999) / 1000;
   localparam int CNT_W         = 4;
   // =====================================================
   // reset values
   localparam logic [WAKE_W-1:0] WAKE_RST = 16'h0000;
   // =====================================================
   // carriers
   typedef struct packed {
      logic [GROUP_W-1:0]   upperWakeupJumpers;
      logic [GROUP_W-1:0]   lowerWakeupJumpers;
      logic                 pageSelectJumper;
      logic                 portWidthJumper;
      logic                 busWidthJumper;
      logic [IRQ_SEL_W-1:0] interruptLevelStrap;
   } strap_t;
   localparam int STRAP_W = $bits(strap_t);

   typedef struct packed {
      logic [ADDR24_W-1:0]  wakeAddr;
      logic [WAKE_W-1:0]    portMatch;
      logic [WAKE_W-1:0]    portMask;
      logic                 port16;
      logic                 data16;
      logic [IRQ_SEL_W-1:0] irqSel;
   } config_t;

   typedef enum logic [1:0] {
      ST_WAIT   = 2'b00,
      ST_SAMPLE = 2'b01,
      ST_HOLD   = 2'b10
   } state_t;
endpackage

// file: rtl/strap_sync.sv
// module: three-stage strap synchroniser, change accepted when stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module strap_sync
#(
   parameter int W = 1
)
(
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rstn,
   input  wire logic         clkEn,
   // pins in, stable value out
   input  wire logic [W-1:0] pinIn,
   output var  logic [W-1:0] stableOut
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] stable;
   } sync_t;
   sync_t sync_reg;
   sync_t sync_next;

   // shift chain; first stage feeds only the second
   always_comb
   begin
      sync_next        = sync_reg;
      sync_next.s1     = pinIn;
      sync_next.s2     = sync_reg.s1;
      sync_next.s3     = sync_reg.s2;
      for (int i = 0; i < W; i++)
      begin
         if (sync_reg.s2[i] == sync_reg.s3[i])
            sync_next.stable[i] = sync_reg.s3[i];
      end
   end

   // registers
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         sync_reg <= '0;
      else if (clkEn)
         sync_reg <= sync_next;
   end

   assign stableOut = sync_reg.stable;
endmodule // strap_sync
`default_nettype wire

// file: rtl/wakeup_address_config.sv
// module: decodes configuration straps into wake-up address, port, widths and interrupt line
`timescale 1ns/1ps
`default_nettype none
module wakeup_address_config
   import wakeup_cfg_pkg::*;
(
   // clock, reset and enable
   input  wire logic                                   clk,
   input  wire logic                                   rstn,
   input  wire logic                                   clkEn,
   // strap pins, high when a jumper is fitted
   input  wire wakeup_cfg_pkg::strap_t                 strapPins,
   // host I/O cycle observed on the system bus
   input  wire logic                                   ioWrite,
   input  wire logic [wakeup_cfg_pkg::WAKE_W-1:0]      ioPort,
   // internal interrupt request
   input  wire logic                                   irqReq,
   // decoded configuration
   output var  wakeup_cfg_pkg::config_t                cfgOut,
   output var  logic                                   cfgValid,
   // wake-up start and first fetch address
   output var  logic                                   wakeStart,
   output var  logic [wakeup_cfg_pkg::ADDR24_W-1:0]    fetchAddr,
   // data path and interrupt lines
   output var  logic                                   memXfer16,
   output var  logic [wakeup_cfg_pkg::IRQ_LINES-1:0]   irqLines
);
   import wakeup_cfg_pkg::*;

   // =====================================================
   // strap synchroniser
   strap_t strapSync;

   strap_sync #(.W(STRAP_W)) u_sync
   (
      .clk       (clk),
      .rstn      (rstn),
      .clkEn     (clkEn),
      .pinIn     (strapPins),
      .stableOut (strapSync)
   );

   // =====================================================
   // state
   typedef struct packed {
      state_t                st;
      logic [CNT_W-1:0]      cnt;
      config_t               cfg;
      logic                  valid;
      logic                  wake;
      logic [ADDR24_W-1:0]   fetch;
      logic                  x16;
      logic [IRQ_LINES-1:0]  irq;
   } core_t;
   core_t core_reg;
   core_t core_next;

   localparam logic [CNT_W-1:0] SETTLE_LAST = CNT_W'(SETTLE_CYC + SYNC_STAGES);

   logic [WAKE_W-1:0] wakeVal;
   logic              portHit;

   // wake-up value assembly, fitted jumper is one
   assign wakeVal = {strapSync.upperWakeupJumpers,
                     strapSync.lowerWakeupJumpers};

   // port compare under the held mask
   assign portHit = ((ioPort & core_reg.cfg.portMask)
                     == (core_reg.cfg.portMatch & core_reg.cfg.portMask));

   // sequencer and decode
   always_comb
   begin
      core_next      = core_reg;
      core_next.wake = 1'b0;
      case (core_reg.st)
         ST_WAIT:
         begin
            // count enabled edges while the synchroniser settles
            core_next.cnt = core_reg.cnt + CNT_W'(1);
            if (core_reg.cnt == SETTLE_LAST)
               core_next.st = ST_SAMPLE;
         end
         ST_SAMPLE:
         begin
            // single capture after reset release
            core_next.cfg.wakeAddr[ADDR20_W-1:0] = {wakeVal, 4'h0};
            core_next.cfg.wakeAddr[ADDR24_W-1:PAGE_LSB] =
               strapSync.pageSelectJumper ? PAGE_HIGH : PAGE_LOW;
            core_next.cfg.portMatch = wakeVal;
            core_next.cfg.port16    = strapSync.portWidthJumper;
            core_next.cfg.portMask  = strapSync.portWidthJumper ?
                                      16'hffff : 16'h00ff;
            core_next.cfg.data16    = strapSync.busWidthJumper;
            core_next.cfg.irqSel    = strapSync.interruptLevelStrap;
            core_next.valid         = 1'b1;
            core_next.st            = ST_HOLD;
         end
         ST_HOLD:
         begin
            // host wakes the controller with a port write
            if (ioWrite && portHit)
            begin
               core_next.wake  = 1'b1;
               core_next.fetch = core_reg.cfg.wakeAddr;
            end
         end
         default:
            core_next.st = ST_WAIT;
      endcase
      // width and interrupt outputs follow the held configuration
      core_next.x16 = core_reg.valid & core_reg.cfg.data16;
      core_next.irq = '0;
      if (core_reg.valid)
         core_next.irq[core_reg.cfg.irqSel] = irqReq;
   end

   // registers
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         core_reg    <= '0;
         core_reg.st <= ST_WAIT;
      end
      else if (clkEn)
         core_reg <= core_next;
   end

   // outputs straight from the state register
   assign cfgOut    = core_reg.cfg;
   assign cfgValid  = core_reg.valid;
   assign wakeStart = core_reg.wake;
   assign fetchAddr = core_reg.fetch;
   assign memXfer16 = core_reg.x16;
   assign irqLines  = core_reg.irq;

   // =====================================================
   // assertions: shared clock and reset
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   // =====================================================
   // assertions: strap capture and hold
   // nothing leaves the block before the straps are captured
   reset_quiet_a: assert property (!cfgValid |->
      !wakeStart && irqLines == 8'h00 && !memXfer16)
      else $error("outputs active before strap capture");

   // captured wake-up value is the synchronised strap groups, upper group high
   capture_value_a: assert property ($rose(cfgValid) |->
      cfgOut.portMatch[15:8] == $past(strapSync.upperWakeupJumpers) &&
      cfgOut.portMatch[7:0] == $past(strapSync.lowerWakeupJumpers))
      else $error("wake-up value not taken from the strap groups");

   // page bits follow the page jumper seen at capture
   capture_page_a: assert property ($rose(cfgValid) |->
      cfgOut.wakeAddr[23:20] == ($past(strapSync.pageSelectJumper) ? 4'hf : 4'h0))
      else $error("page bits not taken from the page jumper");

   // port and data width selections come from their jumpers
   capture_width_a: assert property ($rose(cfgValid) |->
      cfgOut.port16 == $past(strapSync.portWidthJumper) &&
      cfgOut.data16 == $past(strapSync.busWidthJumper))
      else $error("width selection not taken from straps");

   // interrupt line selection comes from the level strap
   capture_irq_a: assert property ($rose(cfgValid) |->
      cfgOut.irqSel == $past(strapSync.interruptLevelStrap))
      else $error("interrupt line not taken from level strap");

   // captured configuration never moves until the next reset
   hold_cfg_a: assert property (cfgValid && clkEn |=>
      cfgValid && $stable(cfgOut))
      else $error("configuration changed after capture");

   // settle wait stays within its count and shows no configuration
   wait_state_a: assert property (core_reg.st == ST_WAIT |->
      !cfgValid && core_reg.cnt <= SETTLE_LAST)
      else $error("settle wait out of range");

   // the capture state lasts exactly one enabled edge
   sample_step_a: assert property (core_reg.st == ST_SAMPLE && clkEn |=>
      core_reg.st == ST_HOLD && cfgValid)
      else $error("capture not followed by hold");

   // once holding, only a reset leaves the hold state
   hold_state_a: assert property (core_reg.st == ST_HOLD |=>
      core_reg.st == ST_HOLD)
      else $error("hold state left without reset");

   // sequencer never reaches an unused code
   state_legal_a: assert property (
      core_reg.st inside {ST_WAIT, ST_SAMPLE, ST_HOLD})
      else $error("sequencer in unused state");

   // =====================================================
   // assertions: address and port decode
   // low nibble zero and segment value above it
   addr_shift_a: assert property (cfgValid |->
      cfgOut.wakeAddr[3:0] == 4'h0 && cfgOut.wakeAddr[19:4] == cfgOut.portMatch)
      else $error("wake address not segment shifted");

   // page bits only ever all zero or all one
   page_bits_a: assert property (cfgValid |->
      cfgOut.wakeAddr[23:20] inside {4'h0, 4'hf})
      else $error("page bits not all zero or all one");

   // port mask covers the byte or the whole word
   port_mask_a: assert property (cfgValid |->
      cfgOut.portMask == (cfgOut.port16 ? 16'hffff : 16'h00ff))
      else $error("port mask does not follow port width");

   // a matching write wakes next edge with the first block address
   wake_port_a: assert property (cfgValid && clkEn && ioWrite &&
      ((ioPort ^ cfgOut.portMatch) & cfgOut.portMask) == 16'h0000
      |=> wakeStart && fetchAddr == $past(cfgOut.wakeAddr))
      else $error("matching port write did not wake");

   // a non-matching write never wakes
   wake_miss_a: assert property (clkEn && ioWrite &&
      ((ioPort ^ cfgOut.portMatch) & cfgOut.portMask) != 16'h0000 |=> !wakeStart)
      else $error("wake on non-matching port");

   // byte port mode ignores the upper port bits
   port8_low_a: assert property (cfgValid && clkEn && ioWrite && !cfgOut.port16 &&
      ioPort[7:0] == cfgOut.portMatch[7:0] |=> wakeStart)
      else $error("byte port match did not wake");

   // word port mode refuses a differing upper byte
   port16_high_a: assert property (cfgValid && clkEn && ioWrite &&
      cfgOut.port16 && ioPort[15:8] != cfgOut.portMatch[15:8] |=> !wakeStart)
      else $error("word port mode woke on upper byte mismatch");

   // no write cycle, no wake pulse
   wake_quiet_a: assert property (clkEn && !ioWrite |=>
      !wakeStart)
      else $error("wake pulse without a port write");

   // the fetch address shown with a wake is the first block address
   wake_fetch_a: assert property (wakeStart |->
      fetchAddr == cfgOut.wakeAddr)
      else $error("fetch address differs from wake-up address");

   // the fetch address only moves together with a wake pulse
   fetch_steady_a: assert property ($changed(fetchAddr) |->
      wakeStart)
      else $error("fetch address moved without a wake");

   // =====================================================
   // assertions: interrupt routing and data width
   // at most one interrupt line at a time
   irq_onehot_a: assert property (
      $onehot0(irqLines))
      else $error("more than one interrupt line driven");

   // a request shows on the selected line
   irq_route_a: assert property (cfgValid && clkEn && irqReq |=>
      irqLines[cfgOut.irqSel])
      else $error("interrupt not on selected line");

   // no request, all lines quiet
   irq_quiet_a: assert property (clkEn && !irqReq |=>
      irqLines == 8'h00)
      else $error("interrupt line driven without a request");

   // a request drives exactly one line
   irq_single_a: assert property (cfgValid && clkEn && irqReq |=>
      $countones(irqLines) == 1)
      else $error("request not on exactly one line");

   // transfer width is the captured bus width one edge later
   xfer_width_a: assert property (clkEn |=>
      memXfer16 == ($past(cfgValid) && $past(cfgOut.data16)))
      else $error("transfer width not from bus width jumper");

   // once captured, transfer width tracks the data width selection
   xfer_follow_a: assert property (cfgValid && clkEn |=>
      memXfer16 == cfgOut.data16)
      else $error("transfer width differs from data width selection");

   // a low clock enable freezes every output
   freeze_a: assert property (!clkEn |=>
      $stable(cfgOut) && $stable(cfgValid) && $stable(wakeStart) &&
      $stable(fetchAddr) && $stable(irqLines) && $stable(memXfer16))
      else $error("state moved while the clock enable was low");

   // =====================================================
   // cover points for the main scenarios
   wake_c:   cover property (wakeStart);
   page_c:   cover property (cfgValid && cfgOut.wakeAddr[23:20] == 4'hf);
   port16_c: cover property (cfgValid && cfgOut.port16 && wakeStart);
   irq7_c:   cover property (irqLines[7]);
   freeze_c: cover property (cfgValid && !clkEn && ioWrite);
endmodule // wakeup_address_config
`default_nettype wire

// file: bench/host_model.sv
// host side model: issues I/O write cycles to the wake-up port
`timescale 1ns/1ps
`default_nettype none
module host_model
   import wakeup_cfg_pkg::*;
(
   // clock
   input  wire logic                              clk,
   // host I/O write cycle
   output var  logic                              ioWrite,
   output var  logic [wakeup_cfg_pkg::WAKE_W-1:0] ioPort
);
   // idle bus starts low
   initial
   begin
      ioWrite = 1'b0;
      ioPort  = 16'h0000;
   end
   // one write cycle, launched and released at falling edges
   task automatic io_write(input logic [WAKE_W-1:0] port);
      @(negedge clk);
      ioWrite = 1'b1;
      ioPort  = port;
      @(negedge clk);
      ioWrite = 1'b0;
      ioPort  = ~port; // released bus never shows the last port
   endtask
endmodule // host_model
`default_nettype wire

// file: bench/wakeup_address_config_tb.sv
// testbench: strap decoding, wake-up port match and interrupt routing
`timescale 1ns/1ps
`default_nettype none
module wakeup_address_config_tb;
   import wakeup_cfg_pkg::*;
   // =====================================================
   // signals
   logic                 clk;
   logic                 rstn;
   logic                 clkEn;
   logic                 irqReq;
   strap_t               strapPins;
   logic                 ioWrite;
   logic [WAKE_W-1:0]    ioPort;
   config_t              cfgOut;
   logic                 cfgValid;
   logic                 wakeStart;
   logic                 memXfer16;
   logic [ADDR24_W-1:0]  fetchAddr;
   logic [IRQ_LINES-1:0] irqLines;
   int                   err_count;
   int                   total_checks;
   int                   cycles = 0;
   // =====================================================
   // design, host model, clock and timeout
   wakeup_address_config dut_u (.clk(clk), .rstn(rstn), .clkEn(clkEn), .strapPins(strapPins),
      .ioWrite(ioWrite), .ioPort(ioPort), .irqReq(irqReq), .cfgOut(cfgOut),
      .cfgValid(cfgValid), .wakeStart(wakeStart), .fetchAddr(fetchAddr),
      .memXfer16(memXfer16), .irqLines(irqLines));
   host_model host_u (.clk(clk), .ioWrite(ioWrite), .ioPort(ioPort));
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // hang guard, far above the roughly 240 cycles the run needs
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         err_count++;
         finish_test();
      end
   end
   // =====================================================
   // compare and closing tasks
   task automatic chk_bit(input string what, input logic exp, input logic got);
      total_checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("MISMATCH %s expected %b seen %b", what, exp, got);
      end
   endtask
   task automatic chk_vec(input string what, input logic [23:0] exp, input logic [23:0] got);
      total_checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // =====================================================
   // one strap setting: reset, capture, wake-up, interrupt, hold
   task automatic run_cfg(input strap_t s);
      logic [WAKE_W-1:0]   w;
      logic [ADDR24_W-1:0] a;
      int                  n;
      w = {s.upperWakeupJumpers, s.lowerWakeupJumpers};
      a = {(s.pageSelectJumper ? PAGE_HIGH : PAGE_LOW), w, 4'h0};
      strapPins = s;
      rstn = 1'b0;
      repeat (2) @(negedge clk);
      chk_bit("cfgValid in reset", 1'b0, cfgValid);
      rstn = 1'b1;
      irqReq = 1'b1;
      host_u.io_write(w);
      chk_bit("wakeStart early", 1'b0, wakeStart);
      chk_vec("irqLines early", 24'h0, 24'(irqLines));
      irqReq = 1'b0;
      n = 0;
      while (cfgValid !== 1'b1 && n < 40)
      begin
         @(negedge clk);
         n++;
      end
      @(negedge clk);
      strapPins = ~s; // later strap changes must be ignored
      chk_vec("wakeAddr", a, cfgOut.wakeAddr);
      chk_vec("portMatch", 24'(w), 24'(cfgOut.portMatch));
      chk_vec("portMask", s.portWidthJumper ? 24'hffff : 24'hff, 24'(cfgOut.portMask));
      chk_bit("port16", s.portWidthJumper, cfgOut.port16);
      chk_bit("data16", s.busWidthJumper, cfgOut.data16);
      chk_bit("memXfer16", s.busWidthJumper, memXfer16);
      chk_vec("irqSel", 24'(s.interruptLevelStrap), 24'(cfgOut.irqSel));
      host_u.io_write(w ^ 16'hff00);
      chk_bit("wakeStart upper diff", ~s.portWidthJumper, wakeStart);
      host_u.io_write(w ^ 16'h0001);
      chk_bit("wakeStart low diff", 1'b0, wakeStart);
      host_u.io_write(w);
      chk_bit("wakeStart match", 1'b1, wakeStart);
      chk_vec("fetchAddr", a, fetchAddr);
      @(negedge clk);
      chk_bit("wakeStart pulse", 1'b0, wakeStart);
      irqReq = 1'b1;
      @(negedge clk);
      chk_vec("irqLines", 24'(8'h01 << s.interruptLevelStrap), 24'(irqLines));
      irqReq = 1'b0;
      @(negedge clk);
      chk_vec("irqLines idle", 24'h0, 24'(irqLines));
      chk_vec("wakeAddr held", a, cfgOut.wakeAddr);
      // a matching write while the clock enable is low must not be taken
      clkEn = 1'b0;
      host_u.io_write(w);
      chk_bit("wakeStart frozen", 1'b0, wakeStart);
      clkEn = 1'b1;
      $display("test done straps %h", s);
   endtask
   // =====================================================
   // main sequence: every interrupt level, page, port and bus width mix
   initial
   begin
      strap_t s;
      rstn = 1'b0;
      irqReq = 1'b0;
      clkEn = 1'b1;
      strapPins = '0;
      err_count = 0;
      total_checks = 0;
      repeat (6) @(negedge clk);
      for (int k = 0; k < 8; k++)
      begin
         s.upperWakeupJumpers = 8'h3c ^ (8'h80 >> k);
         s.lowerWakeupJumpers = 8'h01 << k;
         s.pageSelectJumper = k[0];
         s.portWidthJumper = k[1];
         s.busWidthJumper = k[2];
         s.interruptLevelStrap = 3'(k);
         run_cfg(s);
      end
      run_cfg('1);
      run_cfg('0);
      finish_test();
   end
endmodule // wakeup_address_config_tb
`default_nettype wire
